/* common/uss_pkg.sv */
// shared constants of the universal serial shift unit
package uss_pkg;
   localparam int          DATA_W        = 8;
   localparam int          CNT_W         = 4;
   // wire mode encodings
   localparam logic [1:0]  WM_OFF        = 2'h0;
   localparam logic [1:0]  WM_THREE      = 2'h1;
   localparam logic [1:0]  WM_TWO        = 2'h2;
   localparam logic [1:0]  WM_TWO_HOLD   = 2'h3;
   // shift clock source encodings
   localparam logic [1:0]  CS_SOFT       = 2'h0;
   localparam logic [1:0]  CS_TIMER      = 2'h1;
   localparam logic [1:0]  CS_PIN        = 2'h2;
   localparam logic [1:0]  CS_PIN_ALT    = 2'h3;
   // reset and counter values
   localparam logic [7:0]  DATA_RST      = 8'h00;
   localparam logic [3:0]  CNT_RST       = 4'h0;
   localparam logic [3:0]  CNT_MAX       = 4'hF;
   localparam logic [3:0]  CNT_ONE       = 4'h1;
   localparam int          MSB           = 7;
   // link rate limits as divisors of the system clock
   localparam int          SYS_CLK_NS    = 50;
   localparam int          TWO_WIRE_DIV  = 16;
   localparam int          THREE_MST_DIV = 2;
   localparam int          THREE_SLV_DIV = 4;
   localparam int          TWO_WIRE_MIN_NS = SYS_CLK_NS * TWO_WIRE_DIV;
   localparam int          THREE_SLV_MIN_NS = SYS_CLK_NS * THREE_SLV_DIV;
endpackage

/* common/uss_edge_if.sv */
// edge events and sampled bits passed from the link clock domain
`timescale 1ns/10ps
interface uss_edge_if;
   logic rise_tog;
   logic rise_bit;
   logic fall_tog;
   logic fall_bit;
   modport link (output rise_tog, output rise_bit, output fall_tog, output fall_bit);
   modport core (input rise_tog, input rise_bit, input fall_tog, input fall_bit);
endinterface

/* design/uss_link_edge.sv */
// link-clock side: samples data in on both shift clock edges
`timescale 1ns/10ps
module uss_link_edge
(
   input  wire logic   i_shift_clock_pin,
   input  wire logic   i_sys_rst,
   input  wire logic   i_serial_data_in_pin,
   uss_edge_if.link    lnk
);
   typedef struct packed {
      logic tog;
      logic smp;
   } uss_edge_t;

   uss_edge_t r_ff;
   uss_edge_t nxt_r;
   uss_edge_t f_ff;
   uss_edge_t nxt_f;

   // each edge flips a toggle; data stays put a full link period
   always_comb
   begin
      nxt_r     = r_ff;
      nxt_f     = f_ff;
      nxt_r.tog = ~r_ff.tog;
      nxt_r.smp = i_serial_data_in_pin;
      nxt_f.tog = ~f_ff.tog;
      nxt_f.smp = i_serial_data_in_pin;
   end

   always_ff @(posedge i_shift_clock_pin or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         r_ff <= '0;
      else
         r_ff <= nxt_r;
   end

   // falling edges need their own register set
   always_ff @(negedge i_shift_clock_pin or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         f_ff <= '0;
      else
         f_ff <= nxt_f;
   end

   assign lnk.rise_tog = r_ff.tog;
   assign lnk.rise_bit = r_ff.smp;
   assign lnk.fall_tog = f_ff.tog;
   assign lnk.fall_bit = f_ff.smp;
endmodule

/* design/uss_core.sv */
// universal serial shift unit: shift register, counter, two-wire control
//
// Overview of operation
// - two-wire clock at most system clock over sixteen
// - three-wire clock: master half, slave quarter
// - eight-bit shift register read and written directly
// - no receive buffer; software fetches bytes promptly
// - register msb drives pin chosen by mode
// - pin clock: output latch changes on opposite clock edge
// - input always sampled from data input pin
// - readable writable four-bit counter flags overflow
// - register and counter share one clock source
// - pin clock: counter counts both edges
// - clock from pin, timer overflow, software
// - two-wire start condition detected, may interrupt
// - hold clock low after start or overflow
// - unit interrupts wake processor from idle
// - two-wire start wakes only while system clock runs
// - edge select flips sample and output edges
// - pin clock: sixteen edges overflow counter
// - three-wire follows data modes 0, 1
// - start detect sets start flag
`timescale 1ns/10ps
module uss_core
(
   input  wire logic          i_clk,
   input  wire logic          i_sys_rst,
   input  wire logic          i_shift_clock_pin,
   input  wire logic          i_serial_data_in_pin,
   input  wire logic [1:0]    i_wire_mode,
   input  wire logic [1:0]    i_clk_src,
   input  wire logic          i_edge_select_bit,
   input  wire logic          i_timer_zero_overflow_source,
   input  wire logic          i_soft_strobe,
   input  wire logic          i_data_wr,
   input  wire logic [7:0]    i_data_wdata,
   input  wire logic          i_cnt_wr,
   input  wire logic [3:0]    i_cnt_wdata,
   input  wire logic          i_ovf_clear,
   input  wire logic          i_start_clear,
   input  wire logic          i_ovf_irq_en,
   input  wire logic          i_start_irq_en,
   output logic [7:0]         o_shift_data,
   output logic [3:0]         o_counter,
   output logic               o_counter_overflow_flag,
   output logic               o_start_detect_flag,
   output logic               o_data_out,
   output logic               o_sda_out,
   output logic               o_sda_oe_n,
   output logic               o_scl_out,
   output logic               o_scl_oe_n,
   output logic               o_irq,
   output logic               o_wake_req
);
   typedef struct packed {
      logic [7:0] sh;
      logic [3:0] cnt;
      logic       ovf;
      logic       start;
      logic       latch;
      logic       hold;
      logic       do_pin;
      logic       sda_oe_n;
      logic       scl_oe_n;
      logic       irq;
      logic       wake;
      logic [1:0] scl_s;
      logic [1:0] di_s;
      logic       di_prev;
      logic [1:0] rt_s;
      logic       rt_prev;
      logic [1:0] ft_s;
      logic       ft_prev;
      logic [1:0] rb_s;
      logic [1:0] fb_s;
   } uss_core_t;

   uss_core_t q_ff;
   uss_core_t nxt_q;

   uss_edge_if u_edge_if ();

   uss_link_edge u_link
   (
      .i_shift_clock_pin    (i_shift_clock_pin),
      .i_sys_rst            (i_sys_rst),
      .i_serial_data_in_pin (i_serial_data_in_pin),
      .lnk                  (u_edge_if.link)
   );

   logic two;
   logic ext;
   logic rise_e;
   logic fall_e;
   logic samp_e;
   logic samp_bit;
   logic cnt_e;
   logic wrap;
   logic scl_hi;
   logic start_evt;
   logic latch_open;

   always_comb
   begin
      nxt_q = q_ff;
      // two-stage synchronisers; stage 0 feeds only stage 1
      nxt_q.scl_s = {q_ff.scl_s[0], i_shift_clock_pin};
      nxt_q.di_s  = {q_ff.di_s[0], i_serial_data_in_pin};
      nxt_q.rt_s  = {q_ff.rt_s[0], u_edge_if.rise_tog};
      nxt_q.ft_s  = {q_ff.ft_s[0], u_edge_if.fall_tog};
      nxt_q.rb_s  = {q_ff.rb_s[0], u_edge_if.rise_bit};
      nxt_q.fb_s  = {q_ff.fb_s[0], u_edge_if.fall_bit};
      nxt_q.di_prev = q_ff.di_s[1];
      nxt_q.rt_prev = q_ff.rt_s[1];
      nxt_q.ft_prev = q_ff.ft_s[1];

      two    = (i_wire_mode == uss_pkg::WM_TWO) || (i_wire_mode == uss_pkg::WM_TWO_HOLD);
      ext    = (i_clk_src == uss_pkg::CS_PIN) || (i_clk_src == uss_pkg::CS_PIN_ALT);
      scl_hi = q_ff.scl_s[1];
      rise_e = q_ff.rt_s[1] ^ q_ff.rt_prev;
      fall_e = q_ff.ft_s[1] ^ q_ff.ft_prev;

      // pick the shift event; one source drives register and counter
      if (ext)
      begin
         samp_e   = i_edge_select_bit ? fall_e : rise_e;
         samp_bit = i_edge_select_bit ? q_ff.fb_s[1] : q_ff.rb_s[1];
         cnt_e    = rise_e | fall_e;
      end
      else
      begin
         samp_e   = (i_clk_src == uss_pkg::CS_TIMER) ? i_timer_zero_overflow_source
                                                     : i_soft_strobe;
         samp_bit = q_ff.di_s[1];
         cnt_e    = samp_e;
      end

      // direct write wins over a shift in the same cycle
      if (i_data_wr)
         nxt_q.sh = i_data_wdata;
      else if (samp_e)
         nxt_q.sh = {q_ff.sh[uss_pkg::MSB-1:0], samp_bit};

      wrap = cnt_e && !i_cnt_wr && (q_ff.cnt == uss_pkg::CNT_MAX);
      if (i_cnt_wr)
         nxt_q.cnt = i_cnt_wdata;
      else if (cnt_e)
         nxt_q.cnt = q_ff.cnt + uss_pkg::CNT_ONE;

      // set wins over a clear in the same cycle
      nxt_q.ovf = wrap || (q_ff.ovf && !i_ovf_clear);

      start_evt   = two && scl_hi && q_ff.di_prev && !q_ff.di_s[1];
      nxt_q.start = start_evt || (q_ff.start && !i_start_clear);

      // transparent while the clock rests at the output-phase level
      latch_open = !ext || (scl_hi == i_edge_select_bit);
      if (latch_open)
         nxt_q.latch = q_ff.sh[uss_pkg::MSB];

      // stretch only once the master has pulled the clock low
      nxt_q.hold = two
                && (q_ff.start || ((i_wire_mode == uss_pkg::WM_TWO_HOLD) && q_ff.ovf))
                && (!scl_hi || q_ff.hold);
      nxt_q.scl_oe_n = !nxt_q.hold;

      // msb reaches the data-out pin or the open-drain data line
      nxt_q.do_pin   = (i_wire_mode == uss_pkg::WM_THREE) ? nxt_q.latch : 1'b1;
      nxt_q.sda_oe_n = !(two && !nxt_q.latch);

      nxt_q.irq  = (nxt_q.ovf && i_ovf_irq_en) || (nxt_q.start && i_start_irq_en);
      // start detection uses pin levels synchronised on i_clk, so it wakes only while i_clk runs
      nxt_q.wake = nxt_q.irq || (two && start_evt);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         q_ff          <= '0;
         q_ff.sh       <= uss_pkg::DATA_RST;
         q_ff.cnt      <= uss_pkg::CNT_RST;
         q_ff.latch    <= 1'b1;
         q_ff.do_pin   <= 1'b1;
         q_ff.sda_oe_n <= 1'b1;
         q_ff.scl_oe_n <= 1'b1;
      end
      else
         q_ff <= nxt_q;
   end

   // no receive buffer: the live register is what software reads
   assign o_shift_data            = q_ff.sh;
   assign o_counter               = q_ff.cnt;
   assign o_counter_overflow_flag = q_ff.ovf;
   assign o_start_detect_flag     = q_ff.start;
   assign o_data_out              = q_ff.do_pin;
   assign o_sda_out               = 1'b0;
   assign o_sda_oe_n              = q_ff.sda_oe_n;
   assign o_scl_out               = 1'b0;
   assign o_scl_oe_n              = q_ff.scl_oe_n;
   assign o_irq                   = q_ff.irq;
   assign o_wake_req              = q_ff.wake;

   // link rates are the peer's duty; the synchronisers need them
   // (two-wire period >= TWO_WIRE_DIV cycles)
   // (three-wire slave period >= THREE_SLV_DIV cycles)

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   AST_SHIFT_IN: assert property (samp_e && !i_data_wr |=>
      q_ff.sh == {$past(q_ff.sh[6:0]), $past(samp_bit)})
      else $error("shift register did not take the sampled bit");

   AST_DATA_WR: assert property (i_data_wr |=> o_shift_data == $past(i_data_wdata))
      else $error("direct write not stored");

   AST_CNT_WRAP: assert property (wrap |=> q_ff.cnt == 4'h0 && q_ff.ovf)
      else $error("counter did not wrap with overflow");

   AST_BOTH_EDGES: assert property (ext && (rise_e || fall_e) && !i_cnt_wr |=>
      q_ff.cnt == $past(q_ff.cnt) + 4'h1)
      else $error("pin edge not counted");

   AST_SET_WINS: assert property (wrap && i_ovf_clear |=> o_counter_overflow_flag)
      else $error("overflow lost to clear");

   AST_START: assert property (start_evt |=> o_start_detect_flag && o_wake_req)
      else $error("start condition not flagged");

   AST_STRETCH: assert property (two && q_ff.hold && q_ff.start && !i_start_clear |=>
      q_ff.hold ##1 !o_scl_oe_n)
      else $error("stretch released before flag clear");

   AST_NO_HOLD_3W: assert property (!two |=> o_scl_oe_n)
      else $error("clock held outside two-wire mode");

   AST_DO_PIN: assert property (i_wire_mode == uss_pkg::WM_THREE |=> o_data_out == q_ff.latch)
      else $error("data out does not follow latch");

   AST_LATCH_CLOSED: assert property (ext && (scl_hi != i_edge_select_bit) |=>
      q_ff.latch == $past(q_ff.latch))
      else $error("latch changed on sampling phase");

   AST_IRQ: assert property (q_ff.ovf && i_ovf_irq_en && !i_ovf_clear |=> o_irq)
      else $error("overflow interrupt missing");

   CV_WRAP: cover property (wrap);
   CV_START: cover property (start_evt);
   CV_STRETCH: cover property (q_ff.hold && !scl_hi);
   CV_EXT_SHIFT: cover property (ext && samp_e);
endmodule

/* verification/uss_peer_model.sv */
// remote three-wire or two-wire master that clocks the unit from the link clock
`timescale 1ns/10ps
module uss_peer_model
(
   input  wire logic        i_lclk,
   input  wire logic        i_miso,
   output logic             o_sck,
   output logic             o_sdi,
   output logic [7:0]       o_rx
);
   // 9 link ticks a half period keeps the clock under the two-wire limit
   localparam int HALF_TICKS = 9;
   logic          last_bit;

   initial
   begin
      o_sck    = 1'b0;
      o_sdi    = 1'b1;
      o_rx     = 8'h00;
      last_bit = 1'b0;
   end

   task automatic half_wait();
      repeat (HALF_TICKS) @(posedge i_lclk);
   endtask

   // mode 0: data set while clock low, both sides sample at the rising edge
   task automatic xfer(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--)
      begin
         o_sdi    = tx[i];
         last_bit = tx[i];
         half_wait();
         o_sck = 1'b1;
         o_rx  = {o_rx[6:0], i_miso};
         half_wait();
         o_sck = 1'b0;
      end
      half_wait();
      // released line must not keep the last bit
      o_sdi = ~last_bit;
   endtask

   // data falls while the clock is high, then the clock is pulled low
   task automatic start_cond();
      o_sdi = 1'b1;
      half_wait();
      o_sck = 1'b1;
      half_wait();
      o_sdi = 1'b0;
      half_wait();
      o_sck = 1'b0;
      half_wait();
   endtask
endmodule

/* verification/uss_core_tb_top.sv */
// self-checking bench for the universal serial shift unit
`timescale 1ns/10ps
module uss_core_tb_top;
   localparam int IN_DLY = 2;
   logic       i_clk, i_sys_rst, lclk, i_edge_select_bit, i_timer_zero_overflow_source;
   logic       i_soft_strobe, i_data_wr, i_cnt_wr, i_ovf_clear, i_start_clear;
   logic       i_ovf_irq_en, i_start_irq_en;
   logic [1:0] i_wire_mode, i_clk_src;
   logic [7:0] i_data_wdata, o_shift_data, peer_rx;
   logic [3:0] i_cnt_wdata, o_counter;
   logic       o_counter_overflow_flag, o_start_detect_flag, o_data_out, o_sda_out;
   logic       o_sda_oe_n, o_scl_out, o_scl_oe_n, o_irq, o_wake_req, peer_sck, peer_sdi;
   logic       sck_wire, sdi_wire;
   int         mismatches, tests_run;

   // open-drain wires: any party pulling low wins
   assign sck_wire = peer_sck & o_scl_oe_n;
   assign sdi_wire = peer_sdi & o_sda_oe_n;

   uss_core u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_shift_clock_pin(sck_wire),
      .i_serial_data_in_pin(sdi_wire), .i_wire_mode(i_wire_mode), .i_clk_src(i_clk_src),
      .i_edge_select_bit(i_edge_select_bit),
      .i_timer_zero_overflow_source(i_timer_zero_overflow_source),
      .i_soft_strobe(i_soft_strobe), .i_data_wr(i_data_wr), .i_data_wdata(i_data_wdata),
      .i_cnt_wr(i_cnt_wr), .i_cnt_wdata(i_cnt_wdata), .i_ovf_clear(i_ovf_clear),
      .i_start_clear(i_start_clear), .i_ovf_irq_en(i_ovf_irq_en),
      .i_start_irq_en(i_start_irq_en), .o_shift_data(o_shift_data), .o_counter(o_counter),
      .o_counter_overflow_flag(o_counter_overflow_flag),
      .o_start_detect_flag(o_start_detect_flag), .o_data_out(o_data_out),
      .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_scl_out(o_scl_out),
      .o_scl_oe_n(o_scl_oe_n), .o_irq(o_irq), .o_wake_req(o_wake_req));

   uss_peer_model u_peer (.i_lclk(lclk), .i_miso(o_data_out), .o_sck(peer_sck),
      .o_sdi(peer_sdi), .o_rx(peer_rx));

   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   initial
   begin
      lclk = 1'b0;
      #7;
      forever #24 lclk = ~lclk;
   end

   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge i_clk);
         #IN_DLY;
      end
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_regs(input logic [3:0] c, input logic [7:0] d);
      i_cnt_wr     = 1'b1;
      i_cnt_wdata  = c;
      i_data_wr    = 1'b1;
      i_data_wdata = d;
      step(1);
      i_cnt_wr  = 1'b0;
      i_data_wr = 1'b0;
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #3_000_000;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial
   begin
      {i_edge_select_bit, i_timer_zero_overflow_source, i_soft_strobe, i_data_wr} = 4'h0;
      {i_cnt_wr, i_ovf_clear, i_start_clear, i_ovf_irq_en, i_start_irq_en} = 5'h00;
      i_wire_mode  = uss_pkg::WM_THREE;
      i_clk_src    = uss_pkg::CS_SOFT;
      i_data_wdata = 8'h00;
      i_cnt_wdata  = 4'h0;
      mismatches   = 0;
      tests_run    = 0;
      i_sys_rst    = 1'b1;
      repeat (10) @(posedge i_clk);
      #IN_DLY;
      i_sys_rst = 1'b0;
      step(3);
      check("reset data", o_shift_data, 8'h00);
      check("reset count", o_counter, 8'h00);
      // three-wire with internal clock: open latch shows the cleared msb
      check("reset pins", {o_data_out, o_sda_oe_n, o_scl_oe_n, o_irq}, 8'h06);
      $display("test reset done");
      // two back-to-back soft shifts from count E wrap the counter
      i_ovf_irq_en = 1'b1;
      wr_regs(4'hE, 8'hA5);
      check("written data", o_shift_data, 8'hA5);
      check("written count", o_counter, 8'h0E);
      i_soft_strobe = 1'b1;
      step(2);
      i_soft_strobe = 1'b0;
      check("soft shift data", o_shift_data, 8'h97);
      check("wrapped count", o_counter, 8'h00);
      check("overflow flag", o_counter_overflow_flag, 8'h01);
      step(1);
      check("overflow irq", o_irq, 8'h01);
      i_ovf_clear = 1'b1;
      step(1);
      i_ovf_clear = 1'b0;
      step(2);
      check("cleared flag irq", {o_counter_overflow_flag, o_irq}, 8'h00);
      $display("test soft clock done");
      // timer source ignores the soft strobe
      i_clk_src     = uss_pkg::CS_TIMER;
      i_soft_strobe = 1'b1;
      step(1);
      i_soft_strobe                = 1'b0;
      i_timer_zero_overflow_source = 1'b1;
      step(1);
      i_timer_zero_overflow_source = 1'b0;
      check("timer count", o_counter, 8'h01);
      check("timer data", o_shift_data, 8'h2F);
      $display("test timer clock done");
      // full byte exchange clocked by the peer
      i_clk_src = uss_pkg::CS_PIN;
      wr_regs(4'h0, 8'h3C);
      u_peer.xfer(8'hC6);
      step(8);
      check("pin rx data", o_shift_data, 8'hC6);
      check("pin count", o_counter, 8'h00);
      check("pin overflow", o_counter_overflow_flag, 8'h01);
      check("peer rx", peer_rx, 8'h3C);
      $display("test pin clock done");
      // start condition sets the flag and stretches the clock
      i_ovf_clear  = 1'b1;
      i_ovf_irq_en = 1'b0;
      step(1);
      i_ovf_clear    = 1'b0;
      i_start_irq_en = 1'b1;
      i_wire_mode    = uss_pkg::WM_TWO;
      step(4);
      check("no early start", o_start_detect_flag, 8'h00);
      u_peer.start_cond();
      step(4);
      check("start flag", o_start_detect_flag, 8'h01);
      check("start irq wake", {o_irq, o_wake_req}, 8'h03);
      check("stretch on", o_scl_oe_n, 8'h00);
      step(20);
      check("stretch held", {o_scl_oe_n, sck_wire}, 8'h00);
      i_start_clear = 1'b1;
      step(1);
      i_start_clear = 1'b0;
      step(4);
      check("stretch off", {o_scl_oe_n, o_start_detect_flag}, 8'h02);
      $display("test start condition done");
      tally_and_finish();
   end
endmodule
